// [common/uart_status_pkg.sv]
// Constants for the line and modem status block of one serial channel
package uart_status_pkg;

    // Register offsets (host register index)
    localparam logic [3:0] OFS_RX_HOLD = 4'h0;
    localparam logic [3:0] OFS_LINE_STATUS = 4'h5;
    localparam logic [3:0] OFS_SECOND_RESUME = 4'h5;
    localparam logic [3:0] OFS_MODEM_STATUS = 4'h6;

    // Access keys
    localparam logic [7:0] ENHANCED_ACCESS_KEY = 8'hbf;
    localparam int LFC_DIVISOR_LATCH_BIT = 7;
    localparam int HOC_REG_SELECT_BIT = 2;
    localparam int SFS_SELECT_BIT = 2;
    localparam int HOC_LOOPBACK_BIT = 4;

    // Handshake output control bits looped back in loopback
    localparam int HOC_DTR_BIT = 0;
    localparam int HOC_RTS_BIT = 1;
    localparam int HOC_OUT1_BIT = 2;
    localparam int HOC_OUT2_BIT = 3;

    // Receive line status field positions
    localparam int LSR_DATA_READY_BIT = 0;
    localparam int LSR_OVERRUN_BIT = 1;
    localparam int LSR_PARITY_BIT = 2;

    // Modem status field positions
    localparam int MSR_CTS_DELTA_BIT = 0;
    localparam int MSR_DSR_DELTA_BIT = 1;
    localparam int MSR_RI_TRAIL_BIT = 2;
    localparam int MSR_CD_DELTA_BIT = 3;
    localparam int MSR_CTS_BIT = 4;
    localparam int MSR_DSR_BIT = 5;
    localparam int MSR_RI_BIT = 6;
    localparam int MSR_CD_BIT = 7;

    // Reset values and unmapped read value
    localparam logic [7:0] SECOND_RESUME_RESET = 8'h00;
    localparam logic [7:0] MODEM_STATUS_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // Receive buffer shape
    localparam int RX_FIFO_DEPTH = 64;
    localparam int RX_CHAR_BITS = 8;

endpackage : uart_status_pkg

// [logic/pin_sync.sv]
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE = '1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pins
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_sync_q
);

    logic [WIDTH-1:0] meta_q;

    // Idle level at reset keeps the delta flags quiet after release
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= IDLE;
            pin_sync_q <= IDLE;
        end
        else
        begin
            meta_q <= pin_async;
            pin_sync_q <= meta_q;
        end
    end

endmodule : pin_sync

// [logic/rx_char_fifo.sv]
// Receive character buffer holding data with its parity flag
`timescale 1ns/1ps
module rx_char_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 64
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic flush,
    // Write side
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    // Read side
    input wire logic pop,
    output logic [WIDTH-1:0] head_data,
    output logic empty,
    output logic full
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    wire do_push = push && !full;
    wire do_pop = pop && !empty;

    assign empty = (count_q == '0);
    assign full = (count_q == (AW+1)'(DEPTH));
    assign head_data = mem[rd_ptr_q];

    always_ff @(posedge clock)
    begin
        if (do_push)
            mem[wr_ptr_q] <= push_data;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else if (flush)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr_q <= wr_ptr_q + AW'(1);
            if (do_pop)
                rd_ptr_q <= rd_ptr_q + AW'(1);
            if (do_push && !do_pop)
                count_q <= count_q + (AW+1)'(1);
            else if (do_pop && !do_push)
                count_q <= count_q - (AW+1)'(1);
        end
    end

endmodule : rx_char_fifo

// [logic/uart_line_modem_status.sv]
// Receive line status, second resume character and modem status of one channel
//
// Summary of operation
// - Parity flag follows the next unread character
// - Overrun flag sets on arrival into full buffer
// - Character arriving at full buffer is dropped
// - Data ready while buffer holds a character
// - Second resume character behind 0xbf key
// - Second resume character cleared by power-on only
// - Modem status at offset 6, reset zero
// - Bit 7 is carrier, or out2 in loopback
// - Bit 6 is ring, or out1 in loopback
// - Bit 5 is data set ready, or DTR
// - Bit 4 is clear to send, or RTS
// - Bit 3 sets on any carrier change
// - Bit 2 sets on ring pin rising only
// - Bit 1 sets on any data set change
// - Bit 0 sets on any clear-to-send change
// - Change flag and enable raise modem interrupt
// - Loopback joins transmit to receive, outputs to inputs
`timescale 1ns/1ps
module uart_line_modem_status
    import uart_status_pkg::*;
#(
    parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
    // Clock, power-on reset and software reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic soft_reset,
    // Host register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    output logic reg_rvalid_q,
    // Control registers held elsewhere in the channel
    input wire logic [7:0] line_format_control,
    input wire logic [7:0] handshake_output_control,
    input wire logic [7:0] special_function_select,
    input wire logic modem_irq_enable,
    // Received characters from the deserialiser
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char_data,
    input wire logic rx_char_parity_err,
    // Serial data path
    input wire logic tx_serial,
    input wire logic rx_pin,
    output logic rx_serial_q,
    // Modem handshake pins, active low
    input wire logic carrier_detect_in_n,
    input wire logic ring_indicator_in_n,
    input wire logic data_set_ready_in_n,
    input wire logic clear_to_send_in_n,
    // Status outputs
    output logic [7:0] receive_line_status_q,
    output logic [7:0] modem_line_status_q,
    output logic modem_status_irq_q
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic changed(input logic old_v, input logic new_v);
        changed = old_v ^ new_v;
    endfunction : changed

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [4:0] pins_q;
    wire cd_pin_n = pins_q[0];
    wire ri_pin_n = pins_q[1];
    wire dsr_pin_n = pins_q[2];
    wire cts_pin_n = pins_q[3];
    wire rx_pin_s = pins_q[4];

    pin_sync #(
        .WIDTH(5),
        .IDLE(5'h1f)
    ) u_pin_sync (
        .clock(clock),
        .rst_n(rst_n),
        .pin_async({rx_pin, clear_to_send_in_n, data_set_ready_in_n,
            ring_indicator_in_n, carrier_detect_in_n}),
        .pin_sync_q(pins_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    wire loopback = handshake_output_control[HOC_LOOPBACK_BIT];
    wire lfc_normal = !line_format_control[LFC_DIVISOR_LATCH_BIT];
    wire enhanced_key = (line_format_control == ENHANCED_ACCESS_KEY);
    wire sfs_clear = !special_function_select[SFS_SELECT_BIT];
    wire hoc_msr_sel = !handshake_output_control[HOC_REG_SELECT_BIT];

    // Key access shadows the line status at the same offset
    wire sel_second_resume = enhanced_key && sfs_clear
        && (reg_addr == OFS_SECOND_RESUME);
    wire sel_line_status = lfc_normal && (reg_addr == OFS_LINE_STATUS);
    wire sel_modem_status = lfc_normal && hoc_msr_sel && sfs_clear
        && (reg_addr == OFS_MODEM_STATUS);
    wire sel_rx_hold = lfc_normal && (reg_addr == OFS_RX_HOLD);

    wire rd_line_status = reg_rd && sel_line_status;
    wire rd_modem_status = reg_rd && sel_modem_status;
    wire rd_rx_hold = reg_rd && sel_rx_hold;
    wire wr_second_resume = reg_wr && sel_second_resume;

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer and line status

    logic [8:0] head;
    logic fifo_empty;
    logic fifo_full;
    logic overrun_q;

    // A full buffer refuses the push, so the new character is lost
    wire push_char = rx_char_valid && !fifo_full;
    wire overrun_event = rx_char_valid && fifo_full;

    rx_char_fifo #(
        .WIDTH(RX_CHAR_BITS + 1),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .flush(soft_reset),
        .push(push_char),
        .push_data({rx_char_parity_err, rx_char_data}),
        .pop(rd_rx_hold),
        .head_data(head),
        .empty(fifo_empty),
        .full(fifo_full)
    );

    // Arrival in the read cycle still leaves the flag set
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            overrun_q <= 1'b0;
        else if (soft_reset)
            overrun_q <= 1'b0;
        else if (overrun_event)
            overrun_q <= 1'b1;
        else if (rd_line_status)
            overrun_q <= 1'b0;
    end

    logic [7:0] line_status_d;

    always_comb
    begin
        line_status_d = 8'h00;
        line_status_d[LSR_DATA_READY_BIT] = !fifo_empty;
        line_status_d[LSR_OVERRUN_BIT] = overrun_q;
        // Empty buffer has no next character, so no parity error
        line_status_d[LSR_PARITY_BIT] = !fifo_empty && head[8];
    end

    ////////////////////////////////////////////////////////////////////////
    // Second resume character

    logic [7:0] second_resume_char_q;

    // Software reset deliberately absent: only power-on clears it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            second_resume_char_q <= SECOND_RESUME_RESET;
        else if (wr_second_resume)
            second_resume_char_q <= reg_wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Modem status

    logic [3:0] state_d;
    logic [3:0] state_q;
    logic [3:0] delta_q;
    logic ri_pin_prev_q;
    logic state_valid_q;

    // Live input state, pins inverted or control bits in loopback
    always_comb
    begin
        if (loopback)
        begin
            state_d[3] = handshake_output_control[HOC_OUT2_BIT];
            state_d[2] = handshake_output_control[HOC_OUT1_BIT];
            state_d[1] = handshake_output_control[HOC_DTR_BIT];
            state_d[0] = handshake_output_control[HOC_RTS_BIT];
        end
        else
        begin
            state_d[3] = !cd_pin_n;
            state_d[2] = !ri_pin_n;
            state_d[1] = !dsr_pin_n;
            state_d[0] = !cts_pin_n;
        end
    end

    // Ring flag: ring input low to high, seen as status going 1 to 0
    wire cd_change = state_valid_q && changed(state_q[3], state_d[3]);
    wire ri_trail = state_valid_q && state_q[2] && !state_d[2];
    wire dsr_change = state_valid_q && changed(state_q[1], state_d[1]);
    wire cts_change = state_valid_q && changed(state_q[0], state_d[0]);

    logic [3:0] delta_set;
    assign delta_set = {cd_change, ri_trail, dsr_change, cts_change};

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= 4'h0;
            ri_pin_prev_q <= 1'b1;
            state_valid_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            ri_pin_prev_q <= ri_pin_n;
            state_valid_q <= !soft_reset;
        end
    end

    // A change in the read cycle survives the clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            delta_q <= 4'h0;
        else if (soft_reset)
            delta_q <= 4'h0;
        else if (rd_modem_status)
            delta_q <= delta_set;
        else
            delta_q <= delta_q | delta_set;
    end

    wire [7:0] modem_status_d = {state_q, delta_q};

    ////////////////////////////////////////////////////////////////////////
    // Read data

    logic [7:0] rdata_d;

    always_comb
    begin
        if (sel_second_resume)
            rdata_d = second_resume_char_q;
        else if (sel_line_status)
            rdata_d = line_status_d;
        else if (sel_modem_status)
            rdata_d = modem_status_d;
        else if (sel_rx_hold)
            rdata_d = head[7:0];
        else
            rdata_d = UNMAPPED_READ_VALUE;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata_q <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end
        else
        begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd)
                reg_rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status outputs and loopback path

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            receive_line_status_q <= 8'h00;
            modem_line_status_q <= MODEM_STATUS_RESET;
            modem_status_irq_q <= 1'b0;
            rx_serial_q <= 1'b1;
        end
        else
        begin
            receive_line_status_q <= line_status_d;
            modem_line_status_q <= modem_status_d;
            modem_status_irq_q <= modem_irq_enable && (|delta_q);
            // Transmit wraps to receive; the receive pin is ignored
            rx_serial_q <= loopback ? tx_serial : rx_pin_s;
        end
    end

endmodule : uart_line_modem_status

// [testbench/modem_far.sv]
// Behavioural modem transceiver driving the active-low handshake pins
`timescale 1ns/1ps
module modem_far (
    // Control from the bench
    input wire logic [3:0] want,
    input wire logic slow,
    // Pins, active low, idle high
    output logic [3:0] pins_n
);
    initial pins_n = 4'hf;

    // Slow answers land several clocks late, like a sluggish transceiver
    always @(want)
        pins_n <= #(slow ? 300 : 5) ~want;
endmodule : modem_far

// [testbench/uart_status_monitor.sv]
// Assertion checker bound to the line and modem status block
`timescale 1ns/1ps
module uart_status_monitor (
    // Clock and resets
    input wire logic clock,
    input wire logic arst_n,
    input wire logic soft_reset,
    // Inputs
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] handshake_output_control,
    input wire logic modem_irq_enable,
    input wire logic rx_char_valid,
    input wire logic tx_serial,
    input wire logic carrier_detect_in_n,
    input wire logic ring_indicator_in_n,
    input wire logic data_set_ready_in_n,
    input wire logic clear_to_send_in_n,
    // Outputs
    input wire logic [7:0] reg_rdata_q,
    input wire logic rx_serial_q,
    input wire logic [7:0] receive_line_status_q,
    input wire logic [7:0] modem_line_status_q,
    input wire logic modem_status_irq_q
);
    logic [7:0] hoc, modem_line_status;
    assign hoc = handshake_output_control;
    assign modem_line_status = modem_line_status_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n || soft_reset);

    ////////////////////////////////////////////////////////////////
    // Settled only after the two sync flops have flushed
    sequence quiet_s(pin);
        $stable(pin) && $stable(hoc);
    endsequence
    property state_p(pin, lb, st);
        quiet_s(pin) [*8] |-> st == (hoc[4] ? lb : !pin);
    endproperty
    property delta_p(ev, fl);
        ev && !hoc[4] |-> ##[2:8] fl;
    endproperty

    cd_state_a: assert property (state_p(carrier_detect_in_n, hoc[3], modem_line_status[7]))
        else $error("carrier state wrong");
    ri_state_a: assert property (state_p(ring_indicator_in_n, hoc[2], modem_line_status[6]))
        else $error("ring state wrong");
    dsr_state_a: assert property (state_p(data_set_ready_in_n, hoc[0], modem_line_status[5]))
        else $error("data set state wrong");
    cts_state_a: assert property (state_p(clear_to_send_in_n, hoc[1], modem_line_status[4]))
        else $error("clear to send state wrong");
    cd_delta_a: assert property (delta_p($changed(carrier_detect_in_n), modem_line_status[3]))
        else $error("carrier change missed");
    ri_rise_a: assert property (delta_p($rose(ring_indicator_in_n), modem_line_status[2]))
        else $error("ring trailing edge missed");
    irq_flags_a: assert property (modem_status_irq_q == ($past(modem_irq_enable) && |modem_line_status[3:0]))
        else $error("modem interrupt wrong");
    ready_set_a: assert property (rx_char_valid && !reg_rd ##1 !reg_rd
        |-> ##1 receive_line_status_q[0])
        else $error("data ready missing");
    unmapped_zero_a: assert property (reg_rd && reg_addr == 4'h3 |=> reg_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    loop_serial_a: assert property (hoc[4] |=> rx_serial_q == $past(tx_serial))
        else $error("loopback serial wrong");
endmodule : uart_status_monitor

bind uart_line_modem_status uart_status_monitor uart_status_monitor_i (
    .clock, .arst_n, .soft_reset, .reg_addr, .reg_rd, .handshake_output_control,
    .modem_irq_enable, .rx_char_valid, .tx_serial, .carrier_detect_in_n,
    .ring_indicator_in_n, .data_set_ready_in_n, .clear_to_send_in_n, .reg_rdata_q,
    .rx_serial_q, .receive_line_status_q, .modem_line_status_q, .modem_status_irq_q
);

// [testbench/tb.sv]
// Self-checking bench for the line and modem status block
`timescale 1ns/1ps
module tb;
    localparam int DEPTH = 4;
    logic clock, arst_n, soft_reset, reg_rd, reg_wr, modem_irq_enable, reg_rvalid_q;
    logic rx_char_valid, rx_char_parity_err, tx_serial, rx_pin, rx_serial_q, irq, slow, ovr;
    logic [3:0] reg_addr, want, pins_n;
    logic [7:0] reg_wdata, reg_rdata_q, lfc, hoc, sfs, rx_char_data, receive_line_status, modem_line_status, ms, got, x, h;
    int mismatches, compares, seed, i, q[$];

    uart_line_modem_status #(.FIFO_DEPTH(DEPTH)) uart_line_modem_status_i (
        .clock, .arst_n, .soft_reset, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata_q,
        .reg_rvalid_q, .line_format_control(lfc), .handshake_output_control(hoc),
        .special_function_select(sfs), .modem_irq_enable, .rx_char_valid, .rx_char_data,
        .rx_char_parity_err, .tx_serial, .rx_pin, .rx_serial_q,
        .carrier_detect_in_n(pins_n[3]), .ring_indicator_in_n(pins_n[2]),
        .data_set_ready_in_n(pins_n[1]), .clear_to_send_in_n(pins_n[0]),
        .receive_line_status_q(receive_line_status), .modem_line_status_q(modem_line_status), .modem_status_irq_q(irq)
    );
    modem_far modem_far_i (.want, .slow, .pins_n);

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        int n;
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        n = 0;
        while (reg_rvalid_q !== 1'b1 && n < 4)
        begin
            @(negedge clock);
            n++;
        end
        // Read data stands until the next read, so taking it here is safe
        if (n == 4)
        begin
            mismatches++;
            tally_and_finish();
        end
        else
            d = reg_rdata_q;
    endtask : rd

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask : wr

    // Model drops the arrival when full and flags it
    task automatic rx(input logic [8:0] c);
        @(negedge clock);
        {rx_char_parity_err, rx_char_data} = c;
        rx_char_valid = 1'b1;
        @(negedge clock);
        rx_char_valid = 1'b0;
        if (q.size() < DEPTH)
            q.push_back(int'(c));
        else
            ovr = 1'b1;
    endtask : rx

    // Status from pins or loopback; ring flags only on deassert
    task automatic mstep(input logic [7:0] hn, input logic [3:0] w);
        logic [7:0] s;
        @(negedge clock);
        hoc = hn;
        want = w;
        slow = 1'($random(seed));
        modem_irq_enable = 1'($random(seed));
        tx_serial = 1'($random(seed));
        rx_pin = 1'($random(seed));
        s[7:4] = hn[4] ? {hn[3], hn[2], hn[0], hn[1]} : w;
        s[3:0] = ms[3:0] | {s[7] ^ ms[7], ms[6] & ~s[6], s[5] ^ ms[5], s[4] ^ ms[4]};
        ms = s;
        repeat (20) @(negedge clock);
        chk("msr", ms, modem_line_status);
        chk("irq", {7'h0, modem_irq_enable & |ms[3:0]}, {7'h0, irq});
        chk("rx serial", {7'h0, hn[4] ? tx_serial : rx_pin}, {7'h0, rx_serial_q});
        rd(4'h6, got);
        chk("msr read", hn[2] ? 8'h00 : ms, got);
        if (!hn[2])
            ms[3:0] = 4'h0;
    endtask : mstep

    ////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'h18a8;
        {arst_n, soft_reset, reg_rd, reg_wr, rx_char_valid, rx_char_parity_err} = '0;
        {tx_serial, rx_pin, modem_irq_enable, slow, ovr} = '0;
        {reg_addr, want, reg_wdata, hoc, sfs, rx_char_data, ms} = '0;
        lfc = 8'h03;
        repeat (2) @(negedge clock);
        arst_n = 1'b1;
        repeat (4) @(negedge clock);
        rd(4'h6, got);
        chk("msr reset", 8'h00, got);
        rd(4'h3, got);
        chk("unmapped", 8'h00, got);
        lfc = 8'hbf;
        rd(4'h5, got);
        chk("resume reset", 8'h00, got);
        x = 8'($random(seed));
        wr(4'h5, x);
        sfs = 8'h04;
        wr(4'h5, ~x);
        rd(4'h5, got);
        chk("resume hidden", 8'h00, got);
        sfs = 8'h00;
        soft_reset = 1'b1;
        @(negedge clock);
        soft_reset = 1'b0;
        rd(4'h5, got);
        chk("resume", x, got);
        lfc = 8'h03;
        for (i = 0; i <= DEPTH; i++)
            rx({i[0], 8'($random(seed))});
        repeat (DEPTH + 1)
        begin
            rd(4'h5, got);
            x = {5'h0, q.size() != 0 && q[0][8], ovr, q.size() != 0};
            chk("lsr", x, got);
            chk("lsr out", x, receive_line_status);
            ovr = 1'b0;
            rd(4'h0, got);
            if (q.size() != 0)
                chk("rx data", 8'(q.pop_front()), got);
        end
        repeat (40)
        begin
            h = 8'($random(seed)) & 8'h1f;
            mstep(h, h[4] == hoc[4] ? 4'($random(seed)) : want);
        end
        tally_and_finish();
    end
endmodule : tb
